// *** core/dss_mem_if.sv ***
// step table access between sequencer and its memory
`timescale 1ns/1ps
interface dss_mem_if;
    import dss_pkg::*;
    logic [3:0]  raddr;
    dss_step_t   rdata;
    logic        we_lo;
    logic        we_hi;
    logic [3:0]  waddr;
    logic [31:0] wdata;
    modport ctrl (output raddr, we_lo, we_hi, waddr, wdata, input rdata);
    modport mem  (input raddr, we_lo, we_hi, waddr, wdata, output rdata);
endinterface

// *** core/dss_pkg.sv ***
// constants and types of the drum step sequencer
package dss_pkg;
    localparam int          NUM_STEPS      = 16;
    localparam int          PAT_W          = 16;
    localparam int          CNT_W          = 14;
    localparam int          CLK_PERIOD_NS  = 10;
    localparam int          CS_TIME_NS     = 10_000_000;
    localparam int          CYC_PER_CS     = CS_TIME_NS / CLK_PERIOD_NS;
    localparam logic [13:0] MAX_SETTING    = 14'h270f;
    localparam logic [7:0]  ADDR_CTRL      = 8'h00;
    localparam logic [7:0]  ADDR_TIMEBASE  = 8'h04;
    localparam logic [7:0]  ADDR_LAST_STEP = 8'h08;
    localparam logic [7:0]  ADDR_RELAY     = 8'h0c;
    localparam logic [7:0]  CNT_BASE_DEF   = 8'h10;
    localparam logic [7:0]  ADDR_TBL_LO    = 8'h40;
    localparam logic [7:0]  ADDR_TBL_HI    = 8'hbc;
    localparam int          CTRL_START     = 0;
    localparam int          CTRL_JOG       = 1;
    localparam int          CTRL_RESET     = 2;
    localparam int          CTRL_RUN       = 3;
    localparam int          CTRL_TIMED     = 4;
    localparam int          DONE_BIT       = 16;
    localparam logic [13:0] TIMEBASE_RST   = 14'h0001;
    localparam logic [4:0]  LAST_STEP_RST  = 5'h10;
    localparam logic [4:0]  PRESET_RST     = 5'h01;
    localparam logic [4:0]  STEP_MIN       = 5'h01;
    localparam logic [4:0]  STEP_MAX       = 5'h10;
    localparam logic [1:0]  MODE_TIME      = 2'h0;
    localparam logic [1:0]  MODE_EVENT     = 2'h1;
    localparam logic [1:0]  MODE_TIME_EVT  = 2'h2;
    localparam logic [1:0]  SRC_INPUT      = 2'h0;
    localparam logic [1:0]  SRC_OUTPUT     = 2'h1;
    localparam logic [1:0]  SRC_RELAY      = 2'h2;

    typedef struct packed {
        logic [3:0]       evt_idx;
        logic [1:0]       evt_src;
        logic [1:0]       mode;
        logic [CNT_W-1:0] counts;
        logic [PAT_W-1:0] pattern;
    } dss_step_t;

    typedef enum logic [1:0] {ST_IDLE, ST_RUN, ST_DONE} dss_state_t;
endpackage

// *** core/dss_sequencer.sv ***
// drum step sequencer top with avalon-mm register slave
//
// Design decisions made here: the register addresses and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
// Behaviour
// - sixteen steps, each holding a sixteen-bit output pattern, bit n is column n
// - timed-only variant ignores events and jog; time-and-event variant uses both
// - tick period programmable from 0.01 s to 99.99 s, resolution of step time
// - one shared timebase, per-step count of ticks
// - time in step is 0.01 s times timebase times count, both up to 9999; count is not clamped on write and takes up to 16383
// - on count expiry move to next step and show its pattern
// - time-and-event step: timer runs only while event true, else holds
// - event source is input, output or relay point, polled from step entry
// - each step is time-only, event-only or time-and-event, mixed freely
// - fewer steps or outputs allowed, any step may be the last
// - four consecutive counter words from a configurable base
// - words: ticks in step, timer in 0.01 s, preset step, current step
// - done flag in base word sets at cycle end, clears on reset
// - preset changes only on host write; restart loads the step from it
// - last step met: set done, enter complete state, keep last pattern
// - complete state ignores start and jog
// - leave complete on reset or run entry, clear done, go to preset
// - preset jumps directly to any programmed step
// - sequencer evaluated once per scan tick
// - reset beats start and holds preset step, no timing, no events
// - with reset off each jog rising edge advances one step
// - reset and start off freeze timer and step, outputs kept
// - preset step is a number 1 to 16
module dss_sequencer
    import dss_pkg::*;
#(
    parameter int         P_CYC_PER_CS = CYC_PER_CS,
    parameter logic [7:0] P_CNT_BASE   = CNT_BASE_DEF
)
(
    input  wire logic         i_core_clk,
    input  wire logic         i_sys_rst,
    input  wire logic         i_ce,
    input  wire logic         i_scan_tick,
    input  wire logic [15:0]  i_event,
    input  wire logic [7:0]   i_avs_address,
    input  wire logic         i_avs_read,
    input  wire logic         i_avs_write,
    input  wire logic [31:0]  i_avs_writedata,
    input  wire logic [3:0]   i_avs_byteenable,
    output logic [31:0]       o_avs_readdata,
    output logic              o_avs_waitrequest,
    output logic [PAT_W-1:0]  o_pattern,
    output logic              o_done
);
    localparam int PW = (P_CYC_PER_CS > 1) ? $clog2(P_CYC_PER_CS) : 1;
    localparam logic [PW-1:0] PRESC_LAST = PW'(P_CYC_PER_CS - 1);

    typedef struct packed {
        logic [4:0]  ctrl;
        logic [13:0] timebase;
        logic [4:0]  last_step;
        logic [15:0] relay;
        logic [4:0]  preset;
        logic [4:0]  step;
        logic [15:0] ticks;
        logic [15:0] timer;
        logic        done;
        dss_state_t  st;
        logic        run_prev;
        logic        jog_prev;
        logic [15:0] pend_cs;
        logic [PW-1:0] presc;
        logic        waitreq;
        logic [31:0] rdata;
    } dss_state_s_t;

    dss_state_s_t s_q;
    dss_state_s_t s_d;
    dss_mem_if    mif ();

    logic         req;
    logic         accept;
    logic         jog_edge;
    logic         evt;
    logic         start;
    logic         reset_in;
    logic         timed_only;
    logic [15:0]  tsum;
    logic [7:0]   tbl_off;
    dss_step_t    cfg;

    function automatic logic [4:0] clamp_step(input logic [31:0] v);
        if (v[4:0] < STEP_MIN || v[31:5] != '0)
            clamp_step = (v[31:5] != '0) ? STEP_MAX : STEP_MIN;
        else if (v[4:0] > STEP_MAX)
            clamp_step = STEP_MAX;
        else
            clamp_step = v[4:0];
    endfunction

    function automatic logic [13:0] clamp_setting(input logic [31:0] v);
        if (v[31:14] != '0 || v[13:0] > MAX_SETTING)
            clamp_setting = MAX_SETTING;
        else if (v[13:0] == '0)
            clamp_setting = TIMEBASE_RST;
        else
            clamp_setting = v[13:0];
    endfunction

    function automatic logic [31:0] merge_be(input logic [31:0] old, input logic [31:0] nw,
                                            input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++)
        begin
            if (be[b])
                r[8*b +: 8] = nw[8*b +: 8];
        end
        merge_be = r;
    endfunction

    function automatic logic pick_event(input logic [1:0] src, input logic [3:0] idx,
                                        input logic [15:0] ins, input logic [15:0] outs,
                                        input logic [15:0] rel);
        case (src)
            SRC_INPUT:  pick_event = ins[idx];
            SRC_OUTPUT: pick_event = outs[idx];
            SRC_RELAY:  pick_event = rel[idx];
            default:    pick_event = 1'b0;
        endcase
    endfunction

    assign cfg        = mif.rdata;
    assign req        = i_avs_read | i_avs_write;
    assign accept     = req & ~s_q.waitreq;
    assign start      = s_q.ctrl[CTRL_START];
    assign reset_in   = s_q.ctrl[CTRL_RESET];
    assign timed_only = s_q.ctrl[CTRL_TIMED];
    // jog has no effect in the timed-only variant
    assign jog_edge   = s_q.ctrl[CTRL_JOG] & ~s_q.jog_prev & ~timed_only;
    assign evt        = pick_event(cfg.evt_src, cfg.evt_idx, i_event, cfg.pattern, s_q.relay);
    assign tsum       = s_q.timer + s_q.pend_cs;

    always_comb
    begin
        s_d = s_q;
        // bus slave: one wait cycle, then the answer
        if (req && s_q.waitreq)
        begin
            s_d.waitreq = 1'b0;
            s_d.rdata   = '0;
            case (i_avs_address)
                ADDR_CTRL:      s_d.rdata = {27'h0, s_q.ctrl};
                ADDR_TIMEBASE:  s_d.rdata = {18'h0, s_q.timebase};
                ADDR_LAST_STEP: s_d.rdata = {27'h0, s_q.last_step};
                ADDR_RELAY:     s_d.rdata = {16'h0, s_q.relay};
                P_CNT_BASE:     s_d.rdata = {15'h0, s_q.done, s_q.ticks};
                P_CNT_BASE + 8'h04: s_d.rdata = {16'h0, s_q.timer};
                P_CNT_BASE + 8'h08: s_d.rdata = {27'h0, s_q.preset};
                P_CNT_BASE + 8'h0c: s_d.rdata = {27'h0, s_q.step};
                default:        s_d.rdata = '0;
            endcase
        end
        else if (accept)
        begin
            s_d.waitreq = 1'b1;
        end
        if (accept && i_avs_write)
        begin
            case (i_avs_address)
                ADDR_CTRL:      s_d.ctrl = 5'(merge_be({27'h0, s_q.ctrl}, i_avs_writedata, i_avs_byteenable));
                ADDR_TIMEBASE:  s_d.timebase = clamp_setting(merge_be({18'h0, s_q.timebase},
                                                             i_avs_writedata, i_avs_byteenable));
                ADDR_LAST_STEP: s_d.last_step = clamp_step(merge_be({27'h0, s_q.last_step},
                                                           i_avs_writedata, i_avs_byteenable));
                ADDR_RELAY:     s_d.relay = 16'(merge_be({16'h0, s_q.relay}, i_avs_writedata, i_avs_byteenable));
                P_CNT_BASE + 8'h08: s_d.preset = clamp_step(merge_be({27'h0, s_q.preset},
                                                            i_avs_writedata, i_avs_byteenable));
                default:        s_d.ctrl = s_q.ctrl;
            endcase
        end

        // hundredth-second prescaler, pending hundredths applied at scan
        if (s_q.presc == PRESC_LAST)
        begin
            s_d.presc = '0;
            if (s_q.pend_cs != 16'hffff)
                s_d.pend_cs = s_q.pend_cs + 16'h0001;
        end
        else
        begin
            s_d.presc = s_q.presc + PW'(1);
        end

        // sequencer: evaluated only on the scan tick
        if (i_scan_tick)
        begin
            s_d.pend_cs  = '0;
            s_d.run_prev = s_q.ctrl[CTRL_RUN];
            s_d.jog_prev = s_q.ctrl[CTRL_JOG];
            case (s_q.st)
                ST_IDLE:
                begin
                    if (s_q.ctrl[CTRL_RUN] && !s_q.run_prev)
                    begin
                        s_d.st    = ST_RUN;
                        s_d.step  = s_q.preset;
                        s_d.ticks = '0;
                        s_d.timer = '0;
                        s_d.done  = 1'b0;
                    end
                end
                ST_RUN, ST_DONE:
                begin
                    if (!s_q.ctrl[CTRL_RUN])
                    begin
                        s_d.st = ST_IDLE;
                    end
                    else if (reset_in)
                    begin
                        s_d.st    = ST_RUN;
                        s_d.step  = s_q.preset;
                        s_d.ticks = '0;
                        s_d.timer = '0;
                        s_d.done  = 1'b0;
                    end
                    else if (s_q.st == ST_DONE)
                    begin
                        s_d.st = ST_DONE;
                    end
                    else if (jog_edge || (start && step_met()))
                    begin
                        if (s_q.step == s_q.last_step || s_q.step == STEP_MAX)
                        begin
                            s_d.st   = ST_DONE;
                            s_d.done = 1'b1;
                        end
                        else
                        begin
                            s_d.step  = s_q.step + 5'h01;
                            s_d.ticks = '0;
                            s_d.timer = '0;
                        end
                    end
                    else if (start && run_time())
                    begin
                        if (tsum >= {2'h0, s_q.timebase})
                        begin
                            s_d.ticks = s_q.ticks + 16'h0001;
                            s_d.timer = '0;
                        end
                        else
                        begin
                            s_d.timer = tsum;
                        end
                    end
                end
                default:
                begin
                    s_d.st = ST_IDLE;
                end
            endcase
        end
    end

    // timer may run this scan for the current step
    function automatic logic run_time();
        case (cfg.mode)
            MODE_TIME:     run_time = 1'b1;
            MODE_TIME_EVT: run_time = timed_only | evt;
            default:       run_time = timed_only;
        endcase
    endfunction

    // transition of the current step is met this scan
    function automatic logic step_met();
        logic tick_done;
        tick_done = (tsum >= {2'h0, s_q.timebase}) &&
                    ((s_q.ticks + 16'h0001) >= {2'h0, cfg.counts});
        if (cfg.counts == '0)
            tick_done = 1'b1;
        case (cfg.mode)
            MODE_EVENT:    step_met = timed_only ? tick_done : evt;
            MODE_TIME_EVT: step_met = tick_done && (timed_only || evt);
            default:       step_met = tick_done;
        endcase
    endfunction

    always_ff @(posedge i_core_clk)
    begin
        if (i_sys_rst)
        begin
            s_q           <= '0;
            s_q.timebase  <= TIMEBASE_RST;
            s_q.last_step <= LAST_STEP_RST;
            s_q.preset    <= PRESET_RST;
            s_q.step      <= PRESET_RST;
            s_q.st        <= ST_IDLE;
            s_q.waitreq   <= 1'b1;
        end
        else if (i_ce)
        begin
            s_q <= s_d;
        end
    end

    // memory read follows the next step so data matches the current step
    assign mif.raddr = 4'(s_d.step - 5'h01);
    assign mif.we_lo = accept && i_avs_write && i_avs_address >= ADDR_TBL_LO &&
                       i_avs_address <= ADDR_TBL_HI && !i_avs_address[2];
    assign mif.we_hi = accept && i_avs_write && i_avs_address >= ADDR_TBL_LO &&
                       i_avs_address <= ADDR_TBL_HI && i_avs_address[2];
    // entry index counted from the table base, not from address zero
    assign tbl_off   = i_avs_address - ADDR_TBL_LO;
    assign mif.waddr = tbl_off[6:3];
    assign mif.wdata = i_avs_writedata;

    dss_step_mem u_mem (
        .i_core_clk (i_core_clk),
        .i_sys_rst  (i_sys_rst),
        .i_ce       (i_ce),
        .mem        (mif.mem)
    );

    assign o_avs_readdata    = s_q.rdata;
    assign o_avs_waitrequest = s_q.waitreq;
    assign o_pattern         = cfg.pattern;
    assign o_done            = s_q.done;

    AST_DONE_STATE_FLAG: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
        s_q.st == ST_DONE |-> s_q.done && s_q.step >= STEP_MIN)
        else $error("complete state without done flag");

    AST_RESET_TO_PRESET: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
        i_ce && i_scan_tick && s_q.st != ST_IDLE && s_q.ctrl[CTRL_RUN] && reset_in
        |=> s_q.step == $past(s_q.preset) && s_q.ticks == '0 && s_q.timer == '0 && !s_q.done)
        else $error("reset did not hold preset step");

    AST_STOP_FREEZES: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
        i_ce && i_scan_tick && s_q.st == ST_RUN && s_q.ctrl[CTRL_RUN] && !reset_in && !start && !jog_edge
        |=> $stable(s_q.step) && $stable(s_q.timer) && $stable(s_q.ticks))
        else $error("stopped sequencer moved");

    AST_DONE_IGNORES_INPUTS: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
        s_q.st == ST_DONE && s_q.ctrl[CTRL_RUN] && !reset_in
        |=> s_q.st == ST_DONE && $stable(s_q.step))
        else $error("complete state left without reset");

    AST_NEW_STEP_CLEARS: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
        s_q.step != $past(s_q.step) |-> s_q.ticks == '0 && s_q.timer == '0)
        else $error("new step entered with stale counts");

    AST_STEP_RANGE: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
        s_q.preset >= STEP_MIN && s_q.preset <= STEP_MAX && s_q.step >= STEP_MIN && s_q.step <= STEP_MAX)
        else $error("step number out of range");

    AST_PRESET_HOST_ONLY: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
        s_q.preset != $past(s_q.preset)
        |-> $past(accept && i_avs_write && i_avs_address == P_CNT_BASE + 8'h08))
        else $error("preset changed without host write");

    AST_EVENT_HOLDS_TIMER: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
        i_ce && i_scan_tick && s_q.st == ST_RUN && s_q.ctrl[CTRL_RUN] && !reset_in && start && !jog_edge
        && !timed_only && cfg.mode == MODE_TIME_EVT && !evt |=> $stable(s_q.timer) && $stable(s_q.step))
        else $error("timer ran with event false");

    AST_BUS_ONE_WAIT: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
        i_ce && req && s_q.waitreq |=> !s_q.waitreq)
        else $error("bus answer late");
endmodule

// *** core/dss_step_mem.sv ***
// step table memory with registered read data
`timescale 1ns/1ps
module dss_step_mem
    import dss_pkg::*;
(
    input  wire logic i_core_clk,
    input  wire logic i_sys_rst,
    input  wire logic i_ce,
    dss_mem_if.mem    mem
);
    typedef struct packed {
        dss_step_t [NUM_STEPS-1:0] tbl;
        dss_step_t                 rdata;
    } dss_mem_state_t;

    dss_mem_state_t m_q;
    dss_mem_state_t m_d;

    always_comb
    begin
        m_d = m_q;
        if (mem.we_lo)
        begin
            m_d.tbl[mem.waddr].pattern = mem.wdata[15:0];
            m_d.tbl[mem.waddr].counts  = mem.wdata[29:16];
        end
        if (mem.we_hi)
        begin
            m_d.tbl[mem.waddr].mode    = mem.wdata[1:0];
            m_d.tbl[mem.waddr].evt_src = mem.wdata[3:2];
            m_d.tbl[mem.waddr].evt_idx = mem.wdata[7:4];
        end
        m_d.rdata = m_q.tbl[mem.raddr];
    end

    always_ff @(posedge i_core_clk)
    begin
        if (i_sys_rst)
            m_q <= '0;
        else if (i_ce)
            m_q <= m_d;
    end

    assign mem.rdata = m_q.rdata;
endmodule

// *** testbench/dss_host_model.sv ***
// host program model: scan ticks and discrete event points
`timescale 1ns/1ps
module dss_host_model #(
    parameter int P_SCAN_CYC = 4
)
(
    input  wire logic        i_core_clk,
    input  wire logic        i_sys_rst,
    input  wire logic [15:0] i_evt_set,
    output logic      [15:0] o_event,
    output logic             o_scan_tick
);
    int cnt;
    // one scan pulse per period
    always_ff @(posedge i_core_clk)
    begin
        if (i_sys_rst)
        begin
            cnt         <= 0;
            o_scan_tick <= 1'b0;
            o_event     <= 16'h0000;
        end
        else
        begin
            cnt         <= (cnt == P_SCAN_CYC - 1) ? 0 : cnt + 1;
            o_scan_tick <= (cnt == P_SCAN_CYC - 1);
            o_event     <= i_evt_set; // input points
        end
    end
endmodule

// *** testbench/dss_sequencer_test.sv ***
// self-checking bench of the drum step sequencer
`timescale 1ns/1ps
module dss_sequencer_test;
    import dss_pkg::*;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        ce = 1'b1;
    logic [15:0] evt_set = 16'h0000;
    logic [15:0] evt;
    logic        scan;
    logic [7:0]  addr = 8'h00;
    logic        rd_en = 1'b0;
    logic        wr_en = 1'b0;
    logic [31:0] wdata = 32'h0;
    logic [31:0] rdata;
    logic        wreq;
    logic [15:0] pat;
    logic        done;
    int          error_cnt = 0;
    int          total_checks = 0;
    localparam logic [15:0] PATS [3] = '{16'ha5c3, 16'h0f01, 16'h8001};
    localparam logic [31:0] HI [3] = '{32'h2, 32'h0, 32'h1a};

    always #5 clk = ~clk;

    dss_host_model #(.P_SCAN_CYC(4)) u_host (.i_core_clk(clk), .i_sys_rst(rst), .i_evt_set(evt_set),
        .o_event(evt), .o_scan_tick(scan));

    dss_sequencer #(.P_CYC_PER_CS(4)) u_dut (.i_core_clk(clk), .i_sys_rst(rst), .i_ce(ce),
        .i_scan_tick(scan), .i_event(evt), .i_avs_address(addr), .i_avs_read(rd_en),
        .i_avs_write(wr_en), .i_avs_writedata(wdata), .i_avs_byteenable(4'hf),
        .o_avs_readdata(rdata), .o_avs_waitrequest(wreq), .o_pattern(pat), .o_done(done));

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic bus(input logic we, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
        int n;
        n = 0;
        addr  <= a;
        wr_en <= we;
        rd_en <= !we;
        wdata <= wd;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (wreq !== 1'b0 && n < 50);
        rd = rdata;
        if (n >= 50)
        begin
            check(32'h1, 32'h0);
            conclude();
        end
        rd_en <= 1'b0;
        wr_en <= 1'b0;
        @(posedge clk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] x;
        bus(1'b1, a, d, x);
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] x;
        bus(1'b0, a, 32'h0, x);
        check(x, exp);
    endtask

    task automatic scans(input int n);
        repeat (n * 4) @(posedge clk);
    endtask

    task automatic conclude();
        $display("checks %0d mismatches %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    initial
    begin
        #200000;
        error_cnt++;
        conclude();
    end

    initial
    begin
        int n;
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        rd_chk(ADDR_TIMEBASE, 32'h1);
        rd_chk(ADDR_LAST_STEP, 32'h10);
        rd_chk(8'h18, 32'h1);
        rd_chk(8'h1c, 32'h1);
        rd_chk(8'h10, 32'h0);
        $display("test reset values done");
        rd_chk(8'hfc, 32'h0);
        rd_chk(ADDR_TBL_LO, 32'h0);
        wr(8'h18, 32'h0);
        rd_chk(8'h18, 32'h1);
        wr(8'h18, 32'h11);
        rd_chk(8'h18, 32'h10);
        wr(8'h18, 32'h1); // host alone moves the preset
        $display("test refusals and clamps done");
        for (int i = 0; i < 3; i++)
        begin
            wr(ADDR_TBL_LO + 8'(8 * i), {16'h0002, PATS[i]});
            wr(ADDR_TBL_LO + 8'(8 * i + 4), HI[i]);
        end
        wr(ADDR_LAST_STEP, 32'h3);
        wr(ADDR_RELAY, 32'h0);
        wr(ADDR_CTRL, 32'h8);
        scans(2);
        rd_chk(8'h1c, 32'h1);
        check({16'h0, pat}, {16'h0, PATS[0]});
        wr(ADDR_CTRL, 32'h9);
        scans(8);
        rd_chk(8'h1c, 32'h1);
        rd_chk(8'h10, 32'h0);
        $display("test event hold done");
        wr(ADDR_CTRL, 32'h8);
        evt_set <= 16'h0001;
        scans(6);
        rd_chk(8'h1c, 32'h1);
        wr(ADDR_CTRL, 32'ha);
        scans(2);
        wr(ADDR_CTRL, 32'h8);
        scans(2);
        rd_chk(8'h1c, 32'h2);
        rd_chk(8'h10, 32'h0);
        rd_chk(8'h14, 32'h0);
        check({16'h0, pat}, {16'h0, PATS[1]});
        $display("test freeze and jog done");
        wr(ADDR_CTRL, 32'h9);
        scans(8);
        rd_chk(8'h1c, 32'h3);
        check({31'h0, done}, 32'h0);
        wr(ADDR_RELAY, 32'h2);
        // freeze a whole number of scan periods so the hundredth phase is kept
        ce <= 1'b0;
        repeat (32) @(posedge clk);
        check({31'h0, done}, 32'h0);
        ce <= 1'b1;
        n = 0;
        while (done !== 1'b1 && n < 500)
        begin
            @(posedge clk);
            n++;
        end
        @(posedge clk);
        check({31'h0, done}, 32'h1);
        rd_chk(8'h1c, 32'h3);
        rd_chk(8'h10, 32'h10001);
        check({16'h0, pat}, {16'h0, PATS[2]});
        $display("test mixed run to complete done");
        wr(ADDR_CTRL, 32'hb);
        scans(3);
        wr(ADDR_CTRL, 32'h9);
        scans(3);
        rd_chk(8'h1c, 32'h3);
        check({31'h0, done}, 32'h1);
        $display("test complete ignores inputs done");
        wr(8'h18, 32'h2);
        wr(ADDR_CTRL, 32'hd);
        scans(6);
        check({31'h0, done}, 32'h0);
        rd_chk(8'h1c, 32'h2);
        rd_chk(8'h10, 32'h0);
        check({16'h0, pat}, {16'h0, PATS[1]});
        $display("test reset to preset done");
        wr(ADDR_RELAY, 32'h0);
        wr(ADDR_CTRL, 32'h19);
        scans(8);
        check({31'h0, done}, 32'h1);
        rd_chk(8'h1c, 32'h3);
        $display("test timed-only variant done");
        conclude();
    end
endmodule
